// >>> rcs_pkg.sv
// Constants, types and helpers for the reset and clock supervisor.
// Assumes a single 250 MHz core clock and an Avalon-MM register port.

package rcs_pkg;
	localparam int CORE_CLK_MHZ     = 250;
	localparam int SU_WIDTH         = 10;
	localparam int SU_PERIODS       = 1024;
	localparam int SLOW_RC_KHZ      = 512;
	localparam int FAST_RC_KHZ      = 7370;
	localparam int POWERUP_HOLD_US  = 64;
	localparam int FAIL_TIMEOUT_US  = 100;
	localparam int POWERUP_HOLD_CYC = POWERUP_HOLD_US * CORE_CLK_MHZ;
	localparam int FAIL_TIMEOUT_CYC = FAIL_TIMEOUT_US * CORE_CLK_MHZ;
	localparam int WDT_WIDTH        = 16;

	// Register map, byte addresses
	localparam int         ADDR_W      = 4;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_WDT    = 4'h8;

	// Control register fields
	localparam int          CTRL_SWDT     = 0;
	localparam int          CTRL_BOR_LSB  = 1;
	localparam int          CTRL_PLL_LSB  = 3;
	localparam int          CTRL_TUNE_LSB = 8;
	localparam int          TUNE_W        = 6;
	localparam logic [31:0] CTRL_MASK     = 32'h00003F1F;
	localparam logic [31:0] CTRL_RESET    = 32'h00000000;

	// Status register fields; cause bits sit at the bottom
	localparam int CAUSE_POR   = 0;
	localparam int CAUSE_SW    = 1;
	localparam int CAUSE_PIN   = 2;
	localparam int CAUSE_WDT   = 3;
	localparam int CAUSE_BOR   = 4;
	localparam int CAUSE_TRAP  = 5;
	localparam int CAUSE_ILL   = 6;
	localparam int CAUSE_N     = 7;
	localparam int STAT_FAIL   = 7;
	localparam int STAT_OSCREL = 8;
	localparam int STAT_SLEEP  = 9;
	localparam int STAT_IDLE   = 10;

	// Oscillator mode codes of the configuration input
	typedef logic [2:0] rcs_clkmode_t;
	localparam rcs_clkmode_t MODE_FAST_RC         = 3'h0;
	localparam rcs_clkmode_t MODE_LOW_FREQ_XTAL   = 3'h1;
	localparam rcs_clkmode_t MODE_MEDIUM_XTAL     = 3'h2;
	localparam rcs_clkmode_t MODE_FAST_XTAL       = 3'h3;
	localparam rcs_clkmode_t MODE_SECOND_OSC      = 3'h4;
	localparam rcs_clkmode_t MODE_EXTERNAL_CLOCK  = 3'h5;
	localparam rcs_clkmode_t MODE_EXTERNAL_RC     = 3'h6;

	// Brown-out trip selections and their nominal levels
	localparam logic [1:0] BOR_SEL_2V0 = 2'h0;
	localparam logic [1:0] BOR_SEL_2V7 = 2'h1;
	localparam logic [1:0] BOR_SEL_4V2 = 2'h2;
	localparam logic [1:0] BOR_SEL_4V5 = 2'h3;
	localparam int BOR_MV_2V0 = 2000;
	localparam int BOR_MV_2V7 = 2700;
	localparam int BOR_MV_4V2 = 4200;
	localparam int BOR_MV_4V5 = 4500;

	localparam logic [1:0] PLL_SEL_X4  = 2'h0;
	localparam logic [1:0] PLL_SEL_X8  = 2'h1;
	localparam logic [1:0] PLL_SEL_X16 = 2'h2;
	localparam logic [4:0] PLL_X4      = 5'h04;
	localparam logic [4:0] PLL_X8      = 5'h08;
	localparam logic [4:0] PLL_X16     = 5'h10;

	typedef enum logic [2:0] {
		ST_RESET, ST_POWERUP, ST_STARTUP, ST_RUN, ST_IDLE, ST_SLEEP
	} rcs_state_e;

	function automatic logic rcsIsCrystal(input rcs_clkmode_t m);
		return (m == MODE_LOW_FREQ_XTAL) || (m == MODE_MEDIUM_XTAL) ||
			(m == MODE_FAST_XTAL) || (m == MODE_SECOND_OSC);
	endfunction : rcsIsCrystal

	function automatic logic [4:0] rcsPllMult(input logic [1:0] sel);
		case (sel)
			PLL_SEL_X8:  return PLL_X8;
			PLL_SEL_X16: return PLL_X16;
			default:     return PLL_X4;
		endcase
	endfunction : rcsPllMult

	function automatic logic [31:0] rcsMergeBe(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return r;
	endfunction : rcsMergeBe
endpackage : rcs_pkg

// >>> rcs_wdt_if.sv
// Carrier between the supervisor and its watchdog counter.
// Both ends run on the same core clock.
`timescale 1ns/1ps
interface rcs_wdt_if #(parameter int W = 16) ();
	logic         tick;
	logic         enable;
	logic         clear;
	logic [W-1:0] count;
	logic         overflow;
	modport ctrl (output tick, output enable, output clear, input count, input overflow);
	modport cnt (input tick, input enable, input clear, output count, output overflow);
endinterface : rcs_wdt_if

// >>> rcs_watchdog.sv
// Watchdog counter advanced by ticks of the slow internal RC clock.
// Assumes ticks are single-cycle pulses on the core clock.
`timescale 1ns/1ps
module rcs_watchdog #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control and count
	rcs_wdt_if.cnt   wdt
);
	import rcs_pkg::*;

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         ovf_reg;
	logic         ovf_next;

	// Counts only slow RC ticks, so a dead main oscillator does not stop it
	always_comb begin
		count_next = count_reg;
		ovf_next   = 1'b0;
		if (wdt.clear) begin
			count_next = '0;
		end else if (wdt.enable && wdt.tick) begin
			count_next = W'(count_reg + 1'b1);
			ovf_next   = &count_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_reg <= '0;
			ovf_reg   <= 1'b0;
		end else begin
			count_reg <= count_next;
			ovf_reg   <= ovf_next;
		end
	end

	assign wdt.count    = count_reg;
	assign wdt.overflow = ovf_reg;
endmodule : rcs_watchdog

// >>> rcs_reset_clock_supervisor.sv
// Reset combiner, power-up and start-up sequencer, watchdog and clock monitor.
// Assumes core_clk keeps running from its own source; pins are asynchronous.
`timescale 1ns/1ps
module rcs_reset_clock_supervisor #(
	parameter int POWERUP_HOLD_CYC = rcs_pkg::POWERUP_HOLD_CYC,
	parameter int FAIL_TIMEOUT_CYC = rcs_pkg::FAIL_TIMEOUT_CYC,
	parameter int WDT_WIDTH        = rcs_pkg::WDT_WIDTH
) (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	// Avalon-MM register slave
	input  wire logic [rcs_pkg::ADDR_W-1:0] avsAddress,
	input  wire logic                      avsRead,
	input  wire logic                      avsWrite,
	input  wire logic [31:0]               avsWriteData,
	input  wire logic [3:0]                avsByteEnable,
	output logic      [31:0]               avsReadData,
	output logic                           avsWaitRequest,
	// Reset sources, asynchronous pins
	input  wire logic                      porPulse,
	input  wire logic                      brownoutPulse,
	input  wire logic                      masterClearPin_n,
	// Reset sources from the CPU, core clock
	input  wire logic                      softwareResetInstr,
	input  wire logic                      trapConflictReset,
	input  wire logic                      illegalOpReset,
	// Watched clocks, asynchronous
	input  wire logic                      oscClkIn,
	input  wire logic                      slowRcClkIn,
	// Nonvolatile configuration, static
	input  wire rcs_pkg::rcs_clkmode_t     cfgClockMode,
	input  wire logic                      cfgWatchdogEnable,
	input  wire logic                      cfgClockFailMonitor,
	// Power state requests from the CPU
	input  wire logic                      sleepReq,
	input  wire logic                      idleReq,
	input  wire logic                      wakeEvent,
	input  wire logic                      trapAck,
	// Reset and clock control
	output logic                           masterReset,
	output logic                           oscClkRelease,
	output logic                           clockFailTrap,
	output logic                           sysClkFastRc,
	output logic                           slowRcEnable,
	output logic      [4:0]                pllMult,
	output logic      [1:0]                brownoutTrip,
	output logic      [rcs_pkg::TUNE_W-1:0] fastRcTune
);
	import rcs_pkg::*;

	localparam int PWR_W  = $clog2(POWERUP_HOLD_CYC + 1);
	localparam int FAIL_W = $clog2(FAIL_TIMEOUT_CYC + 1);
	localparam int NSYNC  = 5;

	rcs_wdt_if #(.W(WDT_WIDTH)) wdtIf ();

	rcs_watchdog #(
		.W (WDT_WIDTH)
	) uWatchdog (
		.core_clk (core_clk),
		.rst      (rst),
		.wdt      (wdtIf.cnt)
	);

	// Synchronisers: por, brown-out, clear pin, oscillator, slow RC
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync1_next;
	logic [NSYNC-1:0] sync2_reg;
	logic [NSYNC-1:0] sync2_next;
	logic [1:0]       clkPrev_reg;
	logic [1:0]       clkPrev_next;

	always_comb begin
		sync1_next   = {slowRcClkIn, oscClkIn, masterClearPin_n, brownoutPulse, porPulse};
		sync2_next   = sync1_reg;
		clkPrev_next = sync2_reg[4:3];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_reg   <= 5'h04;
			sync2_reg   <= 5'h04;
			clkPrev_reg <= 2'h0;
		end else begin
			sync1_reg   <= sync1_next;
			sync2_reg   <= sync2_next;
			clkPrev_reg <= clkPrev_next;
		end
	end

	logic porSrc;
	logic borSrc;
	logic pinSrc;
	logic oscEdge;
	logic slowRcEdge;

	assign porSrc     = sync2_reg[0];
	assign borSrc     = sync2_reg[1];
	assign pinSrc     = ~sync2_reg[2];
	assign oscEdge    = sync2_reg[3] & ~clkPrev_reg[0];
	assign slowRcEdge = sync2_reg[4] & ~clkPrev_reg[1];

	// Sequencer state
	rcs_state_e          state_reg;
	rcs_state_e          state_next;
	logic                needPwr_reg;
	logic                needPwr_next;
	logic                needSu_reg;
	logic                needSu_next;
	logic                suHold_reg;
	logic                suHold_next;
	logic [PWR_W-1:0]    pwrCnt_reg;
	logic [PWR_W-1:0]    pwrCnt_next;
	logic [SU_WIDTH-1:0] suCnt_reg;
	logic [SU_WIDTH-1:0] suCnt_next;
	logic [FAIL_W-1:0]   failCnt_reg;
	logic [FAIL_W-1:0]   failCnt_next;
	logic                clkFail_reg;
	logic                clkFail_next;
	logic                fastRc_reg;
	logic                fastRc_next;
	logic                mReset_reg;
	logic                mReset_next;
	logic                oscRel_reg;
	logic                oscRel_next;
	logic                slowEn_reg;
	logic                slowEn_next;

	// Bus state
	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [CAUSE_N-1:0] cause_reg;
	logic [CAUSE_N-1:0] cause_next;
	logic [4:0]  pll_reg;
	logic [4:0]  pll_next;

	logic               wdtEn;
	logic               wdtResetHit;
	logic [CAUSE_N-1:0] srcVec;
	logic               anySrc;
	logic               crystal;
	logic               monActive;
	logic               failHit;
	logic               accept;
	logic               wdtSwClear;
	logic               enterLow;

	assign wdtEn = cfgWatchdogEnable | ctrl_reg[CTRL_SWDT];
	// A time-out in sleep only wakes the device
	assign wdtResetHit = wdtIf.overflow && wdtEn && (state_reg != ST_SLEEP);

	always_comb begin
		srcVec             = '0;
		srcVec[CAUSE_POR]  = porSrc;
		srcVec[CAUSE_SW]   = softwareResetInstr;
		srcVec[CAUSE_PIN]  = pinSrc;
		srcVec[CAUSE_WDT]  = wdtResetHit;
		srcVec[CAUSE_BOR]  = borSrc;
		srcVec[CAUSE_TRAP] = trapConflictReset;
		srcVec[CAUSE_ILL]  = illegalOpReset;
	end

	assign anySrc    = |srcVec;
	// After a failover the crystal is no longer the source
	assign crystal   = rcsIsCrystal(cfgClockMode) && !fastRc_reg;
	assign monActive = cfgClockFailMonitor && !fastRc_reg &&
		((state_reg == ST_RUN) || (state_reg == ST_IDLE));
	assign failHit   = monActive && !oscEdge &&
		(failCnt_reg == FAIL_W'(FAIL_TIMEOUT_CYC - 1));
	assign enterLow  = (state_reg == ST_RUN) && (sleepReq || idleReq);

	// Watchdog hookup
	assign wdtIf.tick   = slowRcEdge && slowEn_reg;
	assign wdtIf.enable = wdtEn;
	assign wdtIf.clear  = (enterLow && wdtEn) || wdtSwClear || mReset_reg;

	always_comb begin
		state_next   = state_reg;
		needPwr_next = needPwr_reg;
		needSu_next  = needSu_reg;
		suHold_next  = suHold_reg;
		pwrCnt_next  = pwrCnt_reg;
		suCnt_next   = suCnt_reg;
		fastRc_next  = fastRc_reg;
		case (state_reg)
			ST_RESET: begin
				pwrCnt_next = '0;
				suCnt_next = '0;
				if (needPwr_reg) begin
					state_next = ST_POWERUP;
				end else if (needSu_reg && crystal) begin
					state_next  = ST_STARTUP;
					suHold_next = 1'b1;
				end else begin
					state_next  = ST_RUN;
					needSu_next = 1'b0;
				end
			end
			ST_POWERUP: begin
				pwrCnt_next = PWR_W'(pwrCnt_reg + 1'b1);
				if (pwrCnt_reg == PWR_W'(POWERUP_HOLD_CYC - 1)) begin
					needPwr_next = 1'b0;
					if (needSu_reg && crystal) begin
						state_next  = ST_STARTUP;
						suHold_next = 1'b1;
					end else begin
						state_next  = ST_RUN;
						needSu_next = 1'b0;
					end
				end
			end
			ST_STARTUP: begin
				if (oscEdge) begin
					suCnt_next = SU_WIDTH'(suCnt_reg + 1'b1);
					if (suCnt_reg == SU_WIDTH'(SU_PERIODS - 1)) begin
						state_next  = ST_RUN;
						needSu_next = 1'b0;
						suHold_next = 1'b0;
					end
				end
			end
			ST_RUN: begin
				if (sleepReq) begin
					state_next = ST_SLEEP;
				end else if (idleReq) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (wakeEvent) begin
					state_next = ST_RUN;
				end
			end
			ST_SLEEP: begin
				suCnt_next = '0;
				if (wakeEvent || wdtIf.overflow) begin
					// The oscillator stopped in sleep and must restart
					state_next = crystal ? ST_STARTUP : ST_RUN;
				end
			end
			default: begin
				state_next = ST_RESET;
			end
		endcase
		if (failHit) begin
			fastRc_next = 1'b1;
		end
		if (anySrc) begin
			state_next   = ST_RESET;
			needPwr_next = needPwr_reg | porSrc;
			needSu_next  = needSu_reg | porSrc | borSrc;
			if (porSrc || borSrc) begin
				fastRc_next = 1'b0;
			end
		end
	end

	always_comb begin
		failCnt_next = '0;
		if (monActive && !oscEdge && !failHit) begin
			failCnt_next = FAIL_W'(failCnt_reg + 1'b1);
		end
		// A new failure wins over an acknowledge in the same cycle
		clkFail_next = ((clkFail_reg && !trapAck) || failHit) && !anySrc;
		mReset_next  = anySrc || (state_next == ST_RESET) ||
			(state_next == ST_POWERUP) ||
			((state_next == ST_STARTUP) && suHold_next);
		oscRel_next  = ((state_next == ST_RUN) || (state_next == ST_IDLE)) &&
			!fastRc_next;
		slowEn_next  = wdtEn || (cfgClockFailMonitor && (state_next != ST_SLEEP));
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg   <= ST_RESET;
			needPwr_reg <= 1'b1;
			needSu_reg  <= 1'b1;
			suHold_reg  <= 1'b0;
			pwrCnt_reg  <= '0;
			suCnt_reg   <= '0;
			failCnt_reg <= '0;
			clkFail_reg <= 1'b0;
			fastRc_reg  <= 1'b0;
			mReset_reg  <= 1'b1;
			oscRel_reg  <= 1'b0;
			slowEn_reg  <= 1'b1;
		end else begin
			state_reg   <= state_next;
			needPwr_reg <= needPwr_next;
			needSu_reg  <= needSu_next;
			suHold_reg  <= suHold_next;
			pwrCnt_reg  <= pwrCnt_next;
			suCnt_reg   <= suCnt_next;
			failCnt_reg <= failCnt_next;
			clkFail_reg <= clkFail_next;
			fastRc_reg  <= fastRc_next;
			mReset_reg  <= mReset_next;
			oscRel_reg  <= oscRel_next;
			slowEn_reg  <= slowEn_next;
		end
	end

	// Register bus: one wait state, then the access completes
	logic [31:0] statusWord;
	logic [31:0] wdataLanes;

	assign accept     = (avsRead || avsWrite) && !wait_reg;
	assign wdtSwClear = accept && avsWrite && (avsAddress == ADDR_WDT);
	assign wdataLanes = rcsMergeBe(32'h00000000, avsWriteData, avsByteEnable);

	always_comb begin
		statusWord              = '0;
		statusWord[CAUSE_N-1:0] = cause_reg;
		statusWord[STAT_FAIL]   = clkFail_reg;
		statusWord[STAT_OSCREL] = oscRel_reg;
		statusWord[STAT_SLEEP]  = (state_reg == ST_SLEEP);
		statusWord[STAT_IDLE]   = (state_reg == ST_IDLE);
	end

	always_comb begin
		wait_next  = !((avsRead || avsWrite) && wait_reg);
		rdata_next = rdata_reg;
		ctrl_next  = ctrl_reg;
		cause_next = cause_reg;
		if (avsRead && wait_reg) begin
			case (avsAddress)
				ADDR_CTRL:   rdata_next = ctrl_reg;
				ADDR_STATUS: rdata_next = statusWord;
				ADDR_WDT:    rdata_next = 32'(wdtIf.count);
				default:     rdata_next = 32'h00000000;
			endcase
		end
		if (accept && avsWrite) begin
			if (avsAddress == ADDR_CTRL) begin
				ctrl_next = rcsMergeBe(ctrl_reg, avsWriteData, avsByteEnable) & CTRL_MASK;
			end
			if (avsAddress == ADDR_STATUS) begin
				cause_next = cause_reg & ~wdataLanes[CAUSE_N-1:0];
			end
		end
		// Software enable does not survive a device reset
		if (mReset_reg) begin
			ctrl_next[CTRL_SWDT] = 1'b0;
		end
		cause_next = cause_next | srcVec;
		pll_next   = rcsPllMult(ctrl_next[CTRL_PLL_LSB +: 2]);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h00000000;
			ctrl_reg  <= CTRL_RESET;
			cause_reg <= '0;
			pll_reg   <= PLL_X4;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			ctrl_reg  <= ctrl_next;
			cause_reg <= cause_next;
			pll_reg   <= pll_next;
		end
	end

	assign avsReadData    = rdata_reg;
	assign avsWaitRequest = wait_reg;
	assign masterReset    = mReset_reg;
	assign oscClkRelease  = oscRel_reg;
	assign clockFailTrap  = clkFail_reg;
	assign sysClkFastRc   = fastRc_reg;
	assign slowRcEnable   = slowEn_reg;
	assign pllMult        = pll_reg;
	assign brownoutTrip   = ctrl_reg[CTRL_BOR_LSB +: 2];
	assign fastRcTune     = ctrl_reg[CTRL_TUNE_LSB +: TUNE_W];
endmodule : rcs_reset_clock_supervisor

// >>> rcs_supervisor_checker.sv
// Port-level assertions for the reset and clock supervisor.
// Assumes one core clock and the synchronous reset rst.
`timescale 1ns/1ps
module rcs_supervisor_checker
	import rcs_pkg::*;
(
	// Clock, reset and bus
	input wire logic                        core_clk,
	input wire logic                        rst,
	input wire logic [rcs_pkg::ADDR_W-1:0]  avsAddress,
	input wire logic                        avsRead,
	input wire logic                        avsWrite,
	input wire logic [31:0]                 avsWriteData,
	input wire logic [3:0]                  avsByteEnable,
	input wire logic                        avsWaitRequest,
	// Reset sources and requests
	input wire logic                        porPulse,
	input wire logic                        brownoutPulse,
	input wire logic                        masterClearPin_n,
	input wire logic                        softwareResetInstr,
	input wire logic                        trapConflictReset,
	input wire logic                        illegalOpReset,
	input wire logic                        cfgClockFailMonitor,
	input wire logic                        sleepReq,
	// Outputs watched
	input wire logic                        masterReset,
	input wire logic                        oscClkRelease,
	input wire logic                        clockFailTrap,
	input wire logic                        sysClkFastRc,
	input wire logic                        slowRcEnable,
	input wire logic [4:0]                  pllMult,
	input wire logic [1:0]                  brownoutTrip
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_core_src;
		(softwareResetInstr || trapConflictReset || illegalOpReset) |-> ##[1:2] masterReset;
	endproperty
	a_core_src: assert property (p_core_src) else $error("cpu reset source ignored");

	// Pins pass a two-stage synchroniser, so allow six cycles
	property p_pin_src;
		(porPulse || brownoutPulse || !masterClearPin_n) [*6] |-> masterReset;
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("pin reset source ignored");

	property p_fail_switch;
		$rose(clockFailTrap) |-> ##[0:1] (sysClkFastRc && !oscClkRelease);
	endproperty
	a_fail_switch: assert property (p_fail_switch) else $error("no switch to fast rc");

	property p_fast_sticky;
		$fell(sysClkFastRc) |-> ##[0:2] masterReset;
	endproperty
	a_fast_sticky: assert property (p_fast_sticky) else $error("failover dropped");

	property p_rc_sleep;
		cfgClockFailMonitor && $fell(slowRcEnable) |->
			$past(sleepReq) || $past(sleepReq, 2) || $past(sleepReq, 3);
	endproperty
	a_rc_sleep: assert property (p_rc_sleep) else $error("slow rc stopped");

	property p_one_wait;
		$rose(avsRead || avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus wait state count");

	property p_trip;
		logic [3:0] d;
		(avsWrite && !avsWaitRequest && avsAddress == ADDR_CTRL && avsByteEnable[0],
			d = avsWriteData[4:1]) |-> ##2 brownoutTrip == d[1:0];
	endproperty
	a_trip: assert property (p_trip) else $error("trip select wrong");

	property p_pll;
		logic [3:0] d;
		(avsWrite && !avsWaitRequest && avsAddress == ADDR_CTRL && avsByteEnable[0],
			d = avsWriteData[4:1]) |-> ##2 pllMult ==
			(d[3:2] == 2'h2 ? 5'h10 : (d[3:2] == 2'h1 ? 5'h08 : 5'h04));
	endproperty
	a_pll: assert property (p_pll) else $error("pll factor wrong");

	c_fail: cover property ($rose(clockFailTrap));
	c_sleep: cover property ($fell(slowRcEnable));
	c_release: cover property ($fell(masterReset));
endmodule : rcs_supervisor_checker

bind rcs_reset_clock_supervisor rcs_supervisor_checker u_chk (.core_clk, .rst, .avsAddress,
	.avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsWaitRequest, .porPulse,
	.brownoutPulse, .masterClearPin_n, .softwareResetInstr, .trapConflictReset,
	.illegalOpReset, .cfgClockFailMonitor, .sleepReq, .masterReset, .oscClkRelease,
	.clockFailTrap, .sysClkFastRc, .slowRcEnable, .pllMult, .brownoutTrip);

// >>> rcs_cpu_model.sv
// CPU exception side: acknowledges a clock-failure trap after a set delay.
// Assumes the trap request is a level held until acknowledged.
`timescale 1ns/1ps
module rcs_cpu_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Trap handshake
	input  wire logic       clockFailTrap,
	input  wire logic [7:0] ackDelay,
	output logic            trapAck
);
	logic [7:0] waitCnt;
	initial trapAck = 1'b0;
	// A long delay mimics a handler that is slow to run
	always @(posedge core_clk) begin
		if (rst || !clockFailTrap) begin
			waitCnt <= 8'h00;
			trapAck <= 1'b0;
		end else begin
			waitCnt <= waitCnt + 8'h01;
			trapAck <= (waitCnt == ackDelay);
		end
	end
endmodule : rcs_cpu_model

// >>> reset_clock_supervisor_bench.sv
// Self-checking bench for the reset and clock supervisor.
// Assumes shortened hold, fail timeout and watchdog width parameters.
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t %s", $time, m); end end
module reset_clock_supervisor_bench;
	import rcs_pkg::*;
	localparam int HOLD = 400;
	localparam int OSCP = 5;
	localparam int SU = 1024 * OSCP;
	logic core_clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
	logic [3:0] avsAddress = 4'h0;
	logic [31:0] avsWriteData = 32'h0, avsReadData, q;
	logic [5:0] src = 6'h00, fastRcTune;
	logic oscClkIn = 1'b0, slowRcClkIn = 1'b0, oscRun = 1'b1, cfgWatchdogEnable = 1'b0;
	logic sleepReq = 1'b0, idleReq = 1'b0, wakeEvent = 1'b0;
	rcs_clkmode_t cfgClockMode = MODE_MEDIUM_XTAL;
	logic avsWaitRequest, trapAck, masterReset, oscClkRelease, clockFailTrap, sysClkFastRc;
	logic slowRcEnable;
	logic [4:0] pllMult;
	logic [1:0] brownoutTrip;
	logic [4:0] pllExp [4] = '{5'h04, 5'h08, 5'h10, 5'h04};
	int sBit [7] = '{0, 1, 2, 3, 4, 5, 4};
	int cause [7] = '{1, 5, 6, 2, 4, 0, 4};
	int lo [7] = '{0, 0, 0, 0, SU - 50, HOLD + SU - 50, 0};
	int hi [7] = '{100, 100, 100, 100, SU + 200, HOLD + SU + 200, 100};
	int n, n_fail = 0, n_checks = 0, oscCnt = 0, rcCnt = 0;

	rcs_reset_clock_supervisor #(.POWERUP_HOLD_CYC(HOLD), .FAIL_TIMEOUT_CYC(40), .WDT_WIDTH(4))
	dut (.core_clk, .rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsByteEnable(4'hF), .avsReadData, .avsWaitRequest, .porPulse(src[5]),
		.brownoutPulse(src[4]), .masterClearPin_n(!src[3]), .softwareResetInstr(src[0]),
		.trapConflictReset(src[1]), .illegalOpReset(src[2]), .oscClkIn, .slowRcClkIn,
		.cfgClockMode, .cfgWatchdogEnable, .cfgClockFailMonitor(1'b1), .sleepReq, .idleReq,
		.wakeEvent, .trapAck, .masterReset, .oscClkRelease, .clockFailTrap, .sysClkFastRc,
		.slowRcEnable, .pllMult, .brownoutTrip, .fastRcTune);
	rcs_cpu_model cpu (.core_clk, .rst, .clockFailTrap, .ackDelay(8'h14), .trapAck);

	always #2 core_clk = ~core_clk;
	// Oscillator stands still when stopped; slow RC runs only while enabled
	always @(posedge core_clk) begin
		oscCnt <= (oscCnt == OSCP - 1) ? 0 : oscCnt + 1;
		oscClkIn <= oscRun && (oscCnt < 2);
		rcCnt <= (rcCnt == 7) ? 0 : rcCnt + 1;
		slowRcClkIn <= (slowRcEnable === 1'b1) && (rcCnt < 4);
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do begin
			@(posedge core_clk);
			k++;
		end while (avsWaitRequest !== 1'b0 && k < 50);
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask : bus

	task automatic waitFor(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= lim) begin
			n_fail++;
			complete_run();
		end
	endtask : waitFor

	task automatic fire(input logic [5:0] v);
		@(posedge core_clk);
		src <= v;
		repeat (8) @(posedge core_clk);
		src <= 6'h00;
		waitFor(masterReset, 1'b1, 10);
	endtask : fire

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		`CHK(masterReset, 1'b1, "reset low")
		`CHK(pllMult, 5'h04, "pll reset")
		waitFor(masterReset, 1'b0, 9000);
		`CHK(n >= HOLD + SU - 50, 1'b1, "start-up short")
		`CHK(oscClkRelease, 1'b1, "osc held")
		bus(0, ADDR_CTRL, 0);
		`CHK(q, CTRL_RESET, "ctrl reset")
		bus(0, 4'hC, 0);
		`CHK(q, 32'h0, "unmapped read")
		$display("power-up test done");
		for (int i = 0; i < 4; i++) begin
			bus(1, ADDR_CTRL, 32'((i << 8) | (i << 3) | (i << 1)));
			repeat (2) @(posedge core_clk);
			`CHK(pllMult, pllExp[i], "pll factor")
			`CHK(brownoutTrip, 2'(i), "trip select")
			`CHK(fastRcTune, 6'(i), "rc tune")
		end
		bus(0, ADDR_CTRL, 0);
		`CHK(q, 32'h0000031E, "ctrl readback")
		$display("register test done");
		for (int k = 0; k < 7; k++) begin
			if (k == 6) begin
				cfgClockMode <= MODE_EXTERNAL_CLOCK;
			end
			fire(6'h01 << sBit[k]);
			waitFor(masterReset, 1'b0, 9000);
			`CHK(n >= lo[k] && n < hi[k], 1'b1, "release delay")
			bus(0, ADDR_STATUS, 0);
			`CHK(q[cause[k]], 1'b1, "cause bit")
			bus(1, ADDR_STATUS, 32'h7F);
		end
		cfgClockMode <= MODE_MEDIUM_XTAL;
		$display("reset source test done");
		for (int j = 0; j < 2; j++) begin
			if (j == 1) begin
				cfgWatchdogEnable <= 1'b1;
			end else begin
				bus(1, ADDR_CTRL, 32'h1);
			end
			waitFor(masterReset, 1'b1, 400);
			`CHK(n > 100, 1'b1, "watchdog early")
			cfgWatchdogEnable <= 1'b0;
			waitFor(masterReset, 1'b0, 200);
			bus(0, ADDR_STATUS, 0);
			`CHK(q[CAUSE_WDT], 1'b1, "watchdog cause")
			bus(1, ADDR_STATUS, 32'h7F);
		end
		$display("watchdog test done");
		bus(1, ADDR_CTRL, 32'h1);
		repeat (80) @(posedge core_clk);
		idleReq <= 1'b1;
		@(posedge core_clk);
		idleReq <= 1'b0;
		bus(0, ADDR_WDT, 0);
		`CHK(q < 2, 1'b1, "idle clear")
		bus(1, ADDR_CTRL, 32'h0);
		wakeEvent <= 1'b1;
		@(posedge core_clk);
		wakeEvent <= 1'b0;
		repeat (4) @(posedge core_clk);
		sleepReq <= 1'b1;
		@(posedge core_clk);
		sleepReq <= 1'b0;
		repeat (20) @(posedge core_clk);
		`CHK(slowRcEnable, 1'b0, "rc in sleep")
		`CHK(oscClkRelease, 1'b0, "osc in sleep")
		wakeEvent <= 1'b1;
		@(posedge core_clk);
		wakeEvent <= 1'b0;
		waitFor(oscClkRelease, 1'b1, 8000);
		`CHK(n >= SU - 50, 1'b1, "wake start-up")
		`CHK(masterReset, 1'b0, "wake reset")
		bus(1, ADDR_CTRL, 32'h1);
		sleepReq <= 1'b1;
		@(posedge core_clk);
		sleepReq <= 1'b0;
		n = 0;
		repeat (200) begin
			@(posedge core_clk);
			if (masterReset !== 1'b0) n++;
		end
		`CHK(n, 0, "sleep overflow reset")
		bus(1, ADDR_CTRL, 32'h0);
		bus(0, ADDR_STATUS, 0);
		`CHK(q[STAT_SLEEP], 1'b0, "no wake")
		waitFor(oscClkRelease, 1'b1, 8000);
		$display("power state test done");
		oscRun <= 1'b0;
		waitFor(clockFailTrap, 1'b1, 200);
		`CHK(sysClkFastRc, 1'b1, "fast rc")
		`CHK(oscClkRelease, 1'b0, "osc kept")
		waitFor(clockFailTrap, 1'b0, 100);
		bus(1, ADDR_WDT, 0);
		bus(1, ADDR_CTRL, 32'h1);
		waitFor(masterReset, 1'b1, 400);
		`CHK(n > 100, 1'b1, "watchdog on rc")
		waitFor(masterReset, 1'b0, 200);
		`CHK(sysClkFastRc, 1'b1, "failover lost")
		oscRun <= 1'b1;
		fire(6'h20);
		waitFor(masterReset, 1'b0, 9000);
		`CHK(sysClkFastRc, 1'b0, "failover kept")
		$display("clock fail test done");
		complete_run();
	end
endmodule : reset_clock_supervisor_bench
